// ===== verification/crs_tb.sv
// self-checking bench for the core register set
`include "crs_defs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import crs_pkg::*;
   // ==========================================
   // signals
   logic clock, rst_b, psel, penable, pwrite, pready, pslverr, irq_accept, er, z, s;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, core_rd_data, seed, rd, d, e;
   crs_wr_s core_wr;
   crs_op_s core_rd_op;
   crs_flag_upd_s flag_upd, f;
   crs_irq_s irq;
   logic [15:0] active_sp;
   logic [19:0] pc_out, vector_table_base_out;
   logic [10:0] flags_out, fm;
   logic [15:0] bm [2][7];
   int n_fail, samples_checked;
   int sv [4] = '{31, 32, 0, 63};

   crs_regs u_crs_regs (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .core_wr(core_wr), .core_rd_op(core_rd_op),
      .core_rd_data(core_rd_data), .flag_upd(flag_upd), .irq(irq), .irq_accept(irq_accept),
      .active_sp(active_sp), .pc_out(pc_out), .vector_table_base_out(vector_table_base_out), .flags_out(flags_out));

   // ==========================================
   // helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [10:0] mkf(input logic b, input logic u, input logic i,
                                       input logic [2:0] p);
      return {p, u, i, 1'b0, b, 4'h0};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         n_fail++;
      end
   endtask

   task automatic cf(input logic [10:0] x);
      chk({21'h0, flags_out}, {21'h0, x});
   endtask

   task automatic wrap_up();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         wrap_up();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wf(input logic [10:0] v);
      apb(1'b1, `CRS_OFF_FLG, {21'h0, v});
      fm = v;
      @(negedge clock);
   endtask

   task automatic crd(input crs_kind_e k, input logic [1:0] i, input logic [31:0] x);
      @(posedge clock);
      core_rd_op <= '{k, i};
      @(negedge clock);
      chk(core_rd_data, x);
   endtask

   task automatic cwr(input crs_kind_e k, input logic [1:0] i, input logic [31:0] x);
      @(posedge clock);
      core_wr <= '{1'b1, '{k, i}, x};
      @(posedge clock);
      core_wr.en <= 1'b0;
   endtask

   task automatic ipulse(input crs_irq_s q);
      @(posedge clock);
      irq <= q;
      @(posedge clock);
      irq <= '0;
      @(negedge clock);
   endtask

   // ==========================================
   // clock and stimulus
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   initial begin
      {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
      core_wr = '0;
      core_rd_op = '0;
      flag_upd = '0;
      irq = '0;
      seed = 32'h01ef;
      n_fail = 0;
      samples_checked = 0;
      fm = '0;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      @(negedge clock);
      cf(11'h0);
      for (int b = 0; b < 2; b++) for (int i = 0; i < 7; i++) begin
         d = xs();
         bm[b][i] = d[15:0];
         apb(1'b1, 8'(b * 32 + i * 4), d);
      end
      for (int b = 0; b < 2; b++) for (int i = 0; i < 7; i++) begin
         apb(1'b0, 8'(b * 32 + i * 4), 32'h0);
         chk(rd, {16'h0, bm[b][i]});
         chk({31'h0, er}, 32'h0);
      end
      apb(1'b1, 8'h1c, xs());
      apb(1'b0, 8'h1c, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      for (int b = 0; b < 2; b++) begin
         wf(mkf(1'(b), 1'b0, 1'b0, 3'h0));
         for (int i = 0; i < 4; i++) crd(K_WORD_R, 2'(i), {16'h0, bm[b][i]});
         crd(K_BYTE_H, 2'h1, {24'h0, bm[b][1][15:8]});
         crd(K_BYTE_L, 2'h1, {24'h0, bm[b][1][7:0]});
         crd(K_LONG_R, 2'h0, {bm[b][2], bm[b][0]});
         crd(K_LONG_R, 2'h1, {bm[b][3], bm[b][1]});
         crd(K_ADDR, 2'h1, {16'h0, bm[b][5]});
         crd(K_LONG_A, 2'h0, {bm[b][5], bm[b][4]});
         crd(K_FB, 2'h0, {16'h0, bm[b][6]});
      end
      d = xs();
      cwr(K_BYTE_H, 2'h3, d);
      bm[1][3][15:8] = d[7:0];
      crd(K_WORD_R, 2'h3, {16'h0, bm[1][3]});
      d = xs();
      cwr(K_LONG_R, 2'h1, d);
      apb(1'b0, 8'h2c, 32'h0);
      chk(rd, {16'h0, d[31:16]});
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, {16'h0, bm[0][3]});
      d = xs();
      cwr(K_LONG_A, 2'h0, d);
      apb(1'b0, 8'h34, 32'h0);
      chk(rd, {16'h0, d[31:16]});
      d = xs();
      apb(1'b1, `CRS_OFF_VECTOR_TABLE_BASE, d);
      apb(1'b1, `CRS_OFF_PC, ~d);
      apb(1'b1, `CRS_OFF_SB, d);
      apb(1'b1, `CRS_OFF_USP, {16'h0, d[31:16]});
      apb(1'b1, `CRS_OFF_ISP, d);
      @(negedge clock);
      chk({12'h0, vector_table_base_out}, {12'h0, d[19:0]});
      chk({12'h0, pc_out}, {12'h0, ~d[19:0]});
      crd(K_SB, 2'h0, {16'h0, d[15:0]});
      for (int u = 0; u < 2; u++) begin
         wf(mkf(1'b0, 1'(u), 1'b0, 3'h0));
         e = (u == 1) ? {16'h0, d[31:16]} : {16'h0, d[15:0]};
         chk({16'h0, active_sp}, e);
         crd(K_SP, 2'h0, e);
         cwr(K_SP, 2'h0, ~e);
         crd((u == 1) ? K_USP : K_ISP, 2'h0, {16'h0, ~e[15:0]});
      end
      wf(mkf(1'b0, 1'b1, 1'b1, 3'h3));
      for (int l = 0; l < 8; l++) begin
         @(posedge clock);
         irq <= '{1'b1, 3'(l), 1'b0, 3'h0, 1'b0, 6'h0};
         @(negedge clock);
         chk({31'h0, irq_accept}, {31'h0, l > 3});
      end
      wf(mkf(1'b0, 1'b1, 1'b0, 3'h3));
      chk({31'h0, irq_accept}, 32'h0);
      wf(mkf(1'b1, 1'b1, 1'b1, 3'h2));
      ipulse('{1'b0, 3'h0, 1'b1, 3'h5, 1'b0, 6'h0});
      cf(mkf(1'b1, 1'b0, 1'b0, 3'h5));
      for (int v = 0; v < 4; v++) begin
         wf(mkf(1'b0, 1'b1, 1'b1, 3'h4));
         ipulse('{1'b0, 3'h0, 1'b0, 3'h0, 1'b1, 6'(sv[v])});
         cf(mkf(1'b0, sv[v] > 31, 1'b0, 3'h4));
      end
      apb(1'b1, `CRS_OFF_FLG, 32'hfffffffd);
      apb(1'b0, `CRS_OFF_FLG, 32'h0);
      chk(rd, 32'h7fd);
      wf(11'h0);
      for (int k = 0; k < 40; k++) begin
         d = xs();
         f = '{d[0], d[1], d[2], crs_size_e'(d[4:3] % 3), xs(), d[5], d[6]};
         if (k % 3 == 0) f.result = f.result & {d[31], 15'h0, d[30], 7'h0, d[29], 7'h0};
         case (f.size)
            SZ_BYTE: {z, s} = {f.result[7:0] == 8'h0, f.result[7]};
            SZ_WORD: {z, s} = {f.result[15:0] == 16'h0, f.result[15]};
            default: {z, s} = {f.result == 32'h0, f.result[31]};
         endcase
         if (f.c_en) fm[0] = f.c;
         if (f.zs_en) fm[3:2] = {s, z};
         if (f.o_en) fm[5] = f.o;
         @(posedge clock);
         flag_upd <= f;
         @(posedge clock);
         flag_upd <= '0;
         @(negedge clock);
         cf(fm);
      end
      wrap_up();
   end
endmodule

// ===== verilog/crs_defs.svh
// register offsets, flag bit positions and reset values of the core register set
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH
`define CRS_OFF_BANK0 8'h00
`define CRS_OFF_BANK1 8'h20
`define CRS_OFF_VECTOR_TABLE_BASE 8'h40
`define CRS_OFF_PC 8'h44
`define CRS_OFF_USP 8'h48
`define CRS_OFF_ISP 8'h4c
`define CRS_OFF_SB 8'h50
`define CRS_OFF_FLG 8'h54
`define CRS_OFF_SP 8'h58
`define CRS_BANK_SPAN 8'h1c
`define CRS_BANK_R_LAST 3'h3
`define CRS_BANK_A0 3'h4
`define CRS_BANK_A1 3'h5
`define CRS_BANK_FB 3'h6
`define CRS_FLG_C 0
`define CRS_FLG_D 1
`define CRS_FLG_Z 2
`define CRS_FLG_S 3
`define CRS_FLG_B 4
`define CRS_FLG_O 5
`define CRS_FLG_I 6
`define CRS_FLG_U 7
`define CRS_FLG_IPL_LO 8
`define CRS_FLG_IPL_HI 10
`define CRS_RST_STATE '0
`define CRS_SW_VEC_LAST 6'h1f
`endif

// ===== verilog/crs_pkg.sv
// types shared by the core register set and its users
package crs_pkg;
   typedef struct packed {
      logic [3:0][15:0] r;
      logic [1:0][15:0] a;
      logic [15:0] fb;
   } crs_bank_s;

   typedef enum logic [3:0] {
      K_WORD_R, K_BYTE_H, K_BYTE_L, K_LONG_R, K_ADDR, K_LONG_A,
      K_FB, K_SB, K_SP, K_USP, K_ISP, K_VECTOR_TABLE_BASE, K_PC, K_FLG
   } crs_kind_e;

   typedef struct packed {
      crs_kind_e kind;
      logic [1:0] idx;
   } crs_op_s;

   typedef struct packed {
      logic en;
      crs_op_s op;
      logic [31:0] data;
   } crs_wr_s;

   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} crs_size_e;

   typedef struct packed {
      logic c_en;
      logic c;
      logic zs_en;
      crs_size_e size;
      logic [31:0] result;
      logic o_en;
      logic o;
   } crs_flag_upd_s;

   typedef struct packed {
      logic req_valid;
      logic [2:0] req_level;
      logic hw_ack;
      logic [2:0] new_ipl;
      logic sw_int;
      logic [5:0] sw_vec;
   } crs_irq_s;

   typedef enum logic [3:0] {
      T_NONE, T_BANK, T_VECTOR_TABLE_BASE, T_PC, T_USP, T_ISP, T_SB, T_FLG, T_SP
   } crs_tgt_e;

   typedef struct packed {
      crs_tgt_e kind;
      logic bnk;
      logic [2:0] idx;
   } crs_tgt_s;

   typedef struct packed {
      crs_bank_s [1:0] bank;
      logic [19:0] vector_table_base;
      logic [19:0] pc;
      logic [15:0] user_stack_pointer;
      logic [15:0] interrupt_stack_pointer;
      logic [15:0] sb;
      logic [10:0] processor_flags;
      logic [31:0] prdata;
      logic ack;
      logic slverr;
   } crs_state_s;
endpackage

// ===== verilog/crs_regs.sv
// core register set: two banks, pointers, flags, apb view and core ports
module crs_regs (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input crs_pkg::crs_wr_s core_wr,
   input crs_pkg::crs_op_s core_rd_op,
   output logic [31:0] core_rd_data,
   input crs_pkg::crs_flag_upd_s flag_upd,
   input crs_pkg::crs_irq_s irq,
   output logic irq_accept,
   output logic [15:0] active_sp,
   output logic [19:0] pc_out,
   output logic [19:0] vector_table_base_out,
   output logic [10:0] flags_out
);
   import crs_pkg::*;
`include "crs_defs.svh"

   // ==========================================================
   // helpers
   function automatic crs_tgt_s decode(input logic [7:0] addr);
      crs_tgt_s t;
      logic [7:0] w;
      t = '{kind: T_NONE, bnk: 1'b0, idx: 3'h0};
      w = {addr[7:2], 2'b00};
      if (w >= `CRS_OFF_BANK0 && w < `CRS_OFF_BANK0 + `CRS_BANK_SPAN) begin
         t.kind = T_BANK;
         t.idx = w[4:2];
      end else if (w >= `CRS_OFF_BANK1 && w < `CRS_OFF_BANK1 + `CRS_BANK_SPAN) begin
         t.kind = T_BANK;
         t.bnk = 1'b1;
         t.idx = w[4:2];
      end else if (w == `CRS_OFF_VECTOR_TABLE_BASE) begin
         t.kind = T_VECTOR_TABLE_BASE;
      end else if (w == `CRS_OFF_PC) begin
         t.kind = T_PC;
      end else if (w == `CRS_OFF_USP) begin
         t.kind = T_USP;
      end else if (w == `CRS_OFF_ISP) begin
         t.kind = T_ISP;
      end else if (w == `CRS_OFF_SB) begin
         t.kind = T_SB;
      end else if (w == `CRS_OFF_FLG) begin
         t.kind = T_FLG;
      end else if (w == `CRS_OFF_SP) begin
         t.kind = T_SP;
      end
      return t;
   endfunction

   function automatic logic [15:0] bank_get(input crs_bank_s b, input logic [2:0] i);
      logic [15:0] v;
      v = b.fb;
      if (i <= `CRS_BANK_R_LAST) begin
         v = b.r[i[1:0]];
      end else if (i == `CRS_BANK_A0 || i == `CRS_BANK_A1) begin
         v = b.a[i[0]];
      end
      return v;
   endfunction

   function automatic crs_bank_s bank_set(input crs_bank_s b, input logic [2:0] i,
                                          input logic [15:0] v);
      crs_bank_s n;
      n = b;
      if (i <= `CRS_BANK_R_LAST) begin
         n.r[i[1:0]] = v;
      end else if (i == `CRS_BANK_A0 || i == `CRS_BANK_A1) begin
         n.a[i[0]] = v;
      end else begin
         n.fb = v;
      end
      return n;
   endfunction

   function automatic logic [15:0] sp_of(input crs_state_s st);
      return st.processor_flags[`CRS_FLG_U] ? st.user_stack_pointer : st.interrupt_stack_pointer;
   endfunction

   function automatic logic result_zero(input logic [31:0] r, input crs_size_e sz);
      logic z;
      z = (r == 32'h0000_0000);
      if (sz == SZ_BYTE) begin
         z = (r[7:0] == 8'h00);
      end else if (sz == SZ_WORD) begin
         z = (r[15:0] == 16'h0000);
      end
      return z;
   endfunction

   function automatic logic result_sign(input logic [31:0] r, input crs_size_e sz);
      logic s;
      s = r[31];
      if (sz == SZ_BYTE) begin
         s = r[7];
      end else if (sz == SZ_WORD) begin
         s = r[15];
      end
      return s;
   endfunction

   function automatic logic [31:0] op_read(input crs_state_s st, input crs_op_s op);
      crs_bank_s b;
      logic [31:0] v;
      b = st.bank[st.processor_flags[`CRS_FLG_B]];
      v = 32'h0000_0000;
      case (op.kind)
         K_WORD_R: v = {16'h0000, b.r[op.idx]};
         K_BYTE_H: v = {24'h00_0000, b.r[op.idx][15:8]};
         K_BYTE_L: v = {24'h00_0000, b.r[op.idx][7:0]};
         K_LONG_R: v = op.idx[0] ? {b.r[3], b.r[1]} : {b.r[2], b.r[0]};
         K_ADDR: v = {16'h0000, b.a[op.idx[0]]};
         K_LONG_A: v = {b.a[1], b.a[0]};
         K_FB: v = {16'h0000, b.fb};
         K_SB: v = {16'h0000, st.sb};
         K_SP: v = {16'h0000, sp_of(st)};
         K_USP: v = {16'h0000, st.user_stack_pointer};
         K_ISP: v = {16'h0000, st.interrupt_stack_pointer};
         K_VECTOR_TABLE_BASE: v = {12'h000, st.vector_table_base};
         K_PC: v = {12'h000, st.pc};
         K_FLG: v = {21'h00_0000, st.processor_flags};
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // ==========================================================
   // state
   crs_state_s s_reg;
   crs_state_s s_next;
   crs_tgt_s tgt;
   logic bsel;
   logic zero_calc;
   logic sign_calc;

   assign tgt = decode(paddr);
   assign bsel = s_reg.processor_flags[`CRS_FLG_B];
   assign zero_calc = result_zero(flag_upd.result, flag_upd.size);
   assign sign_calc = result_sign(flag_upd.result, flag_upd.size);

   always_comb begin
      s_next = s_reg;
      // apb: one wait state, read data captured, write taken with pready
      if (s_reg.ack) begin
         s_next.ack = 1'b0;
         s_next.slverr = 1'b0;
         if (pwrite) begin
            case (tgt.kind)
               T_BANK: s_next.bank[tgt.bnk] =
                  bank_set(s_reg.bank[tgt.bnk], tgt.idx, pwdata[15:0]);
               T_VECTOR_TABLE_BASE: s_next.vector_table_base = pwdata[19:0];
               T_PC: s_next.pc = pwdata[19:0];
               T_USP: s_next.user_stack_pointer = pwdata[15:0];
               T_ISP: s_next.interrupt_stack_pointer = pwdata[15:0];
               T_SB: s_next.sb = pwdata[15:0];
               T_FLG: s_next.processor_flags = pwdata[10:0];
               T_SP: begin
                  if (s_reg.processor_flags[`CRS_FLG_U]) begin
                     s_next.user_stack_pointer = pwdata[15:0];
                  end else begin
                     s_next.interrupt_stack_pointer = pwdata[15:0];
                  end
               end
               default: s_next.slverr = 1'b0;
            endcase
         end
      end else if (psel && penable) begin
         s_next.ack = 1'b1;
         s_next.slverr = (tgt.kind == T_NONE);
         case (tgt.kind)
            T_BANK: s_next.prdata = {16'h0000, bank_get(s_reg.bank[tgt.bnk], tgt.idx)};
            T_VECTOR_TABLE_BASE: s_next.prdata = {12'h000, s_reg.vector_table_base};
            T_PC: s_next.prdata = {12'h000, s_reg.pc};
            T_USP: s_next.prdata = {16'h0000, s_reg.user_stack_pointer};
            T_ISP: s_next.prdata = {16'h0000, s_reg.interrupt_stack_pointer};
            T_SB: s_next.prdata = {16'h0000, s_reg.sb};
            T_FLG: s_next.prdata = {21'h00_0000, s_reg.processor_flags};
            T_SP: s_next.prdata = {16'h0000, sp_of(s_reg)};
            default: s_next.prdata = 32'h0000_0000;
         endcase
      end
      // core write port, overrides a same-cycle apb write
      if (core_wr.en) begin
         case (core_wr.op.kind)
            K_WORD_R: s_next.bank[bsel].r[core_wr.op.idx] = core_wr.data[15:0];
            K_BYTE_H: s_next.bank[bsel].r[core_wr.op.idx][15:8] = core_wr.data[7:0];
            K_BYTE_L: s_next.bank[bsel].r[core_wr.op.idx][7:0] = core_wr.data[7:0];
            K_LONG_R: begin
               s_next.bank[bsel].r[{1'b1, core_wr.op.idx[0]}] = core_wr.data[31:16];
               s_next.bank[bsel].r[{1'b0, core_wr.op.idx[0]}] = core_wr.data[15:0];
            end
            K_ADDR: s_next.bank[bsel].a[core_wr.op.idx[0]] = core_wr.data[15:0];
            K_LONG_A: begin
               s_next.bank[bsel].a[1] = core_wr.data[31:16];
               s_next.bank[bsel].a[0] = core_wr.data[15:0];
            end
            K_FB: s_next.bank[bsel].fb = core_wr.data[15:0];
            K_SB: s_next.sb = core_wr.data[15:0];
            K_SP: begin
               if (s_reg.processor_flags[`CRS_FLG_U]) begin
                  s_next.user_stack_pointer = core_wr.data[15:0];
               end else begin
                  s_next.interrupt_stack_pointer = core_wr.data[15:0];
               end
            end
            K_USP: s_next.user_stack_pointer = core_wr.data[15:0];
            K_ISP: s_next.interrupt_stack_pointer = core_wr.data[15:0];
            K_VECTOR_TABLE_BASE: s_next.vector_table_base = core_wr.data[19:0];
            K_PC: s_next.pc = core_wr.data[19:0];
            K_FLG: s_next.processor_flags = core_wr.data[10:0];
            default: s_next.sb = s_next.sb;
         endcase
      end
      // arithmetic flags, only when the instruction defines them
      if (flag_upd.c_en) begin
         s_next.processor_flags[`CRS_FLG_C] = flag_upd.c;
      end
      if (flag_upd.zs_en) begin
         s_next.processor_flags[`CRS_FLG_Z] = zero_calc;
         s_next.processor_flags[`CRS_FLG_S] = sign_calc;
      end
      if (flag_upd.o_en) begin
         s_next.processor_flags[`CRS_FLG_O] = flag_upd.o;
      end
      // interrupt entry wins over any other flag change
      if (irq.sw_int) begin
         s_next.processor_flags[`CRS_FLG_I] = 1'b0;
         if (irq.sw_vec <= `CRS_SW_VEC_LAST) begin
            s_next.processor_flags[`CRS_FLG_U] = 1'b0;
         end
      end
      if (irq.hw_ack) begin
         s_next.processor_flags[`CRS_FLG_I] = 1'b0;
         s_next.processor_flags[`CRS_FLG_U] = 1'b0;
         s_next.processor_flags[`CRS_FLG_IPL_HI:`CRS_FLG_IPL_LO] = irq.new_ipl;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= `CRS_RST_STATE;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // outputs
   assign prdata = s_reg.prdata;
   assign pready = s_reg.ack;
   assign pslverr = s_reg.ack & s_reg.slverr;
   assign core_rd_data = op_read(s_reg, core_rd_op);
   assign active_sp = sp_of(s_reg);
   assign pc_out = s_reg.pc;
   assign vector_table_base_out = s_reg.vector_table_base;
   assign flags_out = s_reg.processor_flags;
   assign irq_accept = irq.req_valid & s_reg.processor_flags[`CRS_FLG_I] &
                       (irq.req_level > s_reg.processor_flags[`CRS_FLG_IPL_HI:`CRS_FLG_IPL_LO]);

   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   sequence seq_access;
      psel && penable && !pready;
   endsequence
   sequence seq_answer;
      pready ##1 !pready;
   endsequence

   a_apb_one_wait: assert property (seq_access |=> seq_answer)
      else $error("apb answer not after one wait state");
   a_hw_ack_u: assert property (irq.hw_ack |=> !flags_out[`CRS_FLG_U])
      else $error("stack select not cleared on acknowledge");
   a_sw_vec_u: assert property (irq.sw_int && irq.sw_vec <= `CRS_SW_VEC_LAST
                                |=> !flags_out[`CRS_FLG_U])
      else $error("stack select not cleared on low software vector");
   a_ack_clears_i: assert property ((irq.hw_ack || irq.sw_int)
                                    |=> !flags_out[`CRS_FLG_I])
      else $error("interrupt enable not cleared");
   a_carry_capture: assert property (flag_upd.c_en && !irq.hw_ack
                                     |=> flags_out[`CRS_FLG_C] == $past(flag_upd.c))
      else $error("carry not captured");
   a_zero_flag: assert property (flag_upd.zs_en
                                 |=> flags_out[`CRS_FLG_Z] == $past(zero_calc))
      else $error("zero flag wrong");
   a_sign_flag: assert property (flag_upd.zs_en
                                 |=> flags_out[`CRS_FLG_S] == $past(sign_calc))
      else $error("sign flag wrong");
   a_ovf_flag: assert property (flag_upd.o_en
                                |=> flags_out[`CRS_FLG_O] == $past(flag_upd.o))
      else $error("overflow flag wrong");
   a_carry_hold: assert property (!flag_upd.c_en && !core_wr.en && !(pready && pwrite)
                                  |=> $stable(flags_out[`CRS_FLG_C]))
      else $error("carry changed without cause");
   a_accept_level: assert property (irq_accept
      |-> irq.req_level > flags_out[`CRS_FLG_IPL_HI:`CRS_FLG_IPL_LO])
      else $error("interrupt accepted at too low a level");
   a_long_pair: assert property (core_rd_op.kind == K_LONG_R && !core_rd_op.idx[0]
      |-> core_rd_data == {s_reg.bank[bsel].r[2], s_reg.bank[bsel].r[0]})
      else $error("long data pair mismatch");
   a_sp_write: assert property (core_wr.en && core_wr.op.kind == K_SP && !pready
      |=> active_sp == $past(core_wr.data[15:0]) || $past(irq.hw_ack)
          || $past(irq.sw_int))
      else $error("active stack pointer not written");
   a_bank_word: assert property (core_rd_op.kind == K_WORD_R
      |-> core_rd_data == {16'h0000, s_reg.bank[bsel].r[core_rd_op.idx]})
      else $error("word read not from active bank");
   a_sp_pick: assert property (active_sp == (flags_out[`CRS_FLG_U] ? s_reg.user_stack_pointer : s_reg.interrupt_stack_pointer))
      else $error("wrong stack pointer active");
   a_sw_high_u: assert property (irq.sw_int && irq.sw_vec > `CRS_SW_VEC_LAST && !irq.hw_ack
      && !core_wr.en && !(pready && pwrite)
      |=> flags_out[`CRS_FLG_U] == $past(flags_out[`CRS_FLG_U]))
      else $error("stack select changed on high software vector");
   a_unmapped_err: assert property (pready && tgt.kind == T_NONE |-> pslverr)
      else $error("unmapped access without error");
endmodule
